// file: rtl/fcrb_regs.svh
// constants for the flash configuration register bank
// Overview of operation
// RQ1: hidden active config loads from nonvolatile on reset
// RQ2: volatile write completion copies into active config
// RQ3: nonvolatile bytes default erased FFh; code defaults 01h to 1Fh and 0Ah to 55h
// RQ4: only low address byte selects register
// RQ5: reserved address reads return FFh
// RQ6: reserved setting write ignored, error, latch cleared
// RQ7: bit6 of 0Bh inverts data line three; code inverts it while bit6 is low
// RQ8: bit3 of 0Bh low enables parity checks
// RQ9: bit2 of 0Bh selects error pin event
// RQ10: bit1 of 0Bh low enables error pin
// RQ11: bit0 of 0Bh low enables correction
// RQ12: byte 0Ah training pattern, default 55h
// RQ13: byte 07h read wrap select
// RQ14: byte 06h execute-in-place mode after reset
// RQ15: byte 05h three or four address bytes
// RQ16: byte 03h output drive strength
// RQ17: byte 01h dummy cycles, 00h as 1Fh
// RQ18: byte 00h I/O protocol select
// RQ19: octal boot parts stay octal DDR strobe
// RQ20: host programs enough dummy cycles
// RQ21: protection error flag is flag bit 1
// RQ22: nonvolatile write acts only after reset
`ifndef FCRB_REGS_SVH
`define FCRB_REGS_SVH
`define FCRB_A_IO      8'h00
`define FCRB_A_DUMMY   8'h01
`define FCRB_A_DRIVE   8'h03
`define FCRB_A_ADDR    8'h05
`define FCRB_A_XIP     8'h06
`define FCRB_A_WRAP    8'h07
`define FCRB_A_PAT     8'h0A
`define FCRB_A_INTEG   8'h0B
`define FCRB_ERASED    8'hFF
`define FCRB_PAT_RST   8'h55
`define FCRB_DUMMY_DEF 8'h1F
`define FCRB_DUMMY_MAX 8'h1E
`define FCRB_INTEG_MSK 8'h4F
`define FCRB_B_SSO     6
`define FCRB_B_PAR     3
`define FCRB_B_EVT     2
`define FCRB_B_PIN     1
`define FCRB_B_ECC     0
`define FCRB_FLAG_PROT 1
`define FCRB_SYNC_ARM  2'h3
`endif

// file: rtl/fcrb_pkg.sv
// types for the flash configuration register bank
package fcrb_pkg;
	typedef struct packed {
		logic [7:0] io_mode;
		logic [7:0] dummy;
		logic [7:0] drive;
		logic [7:0] addr_len;
		logic [7:0] xip;
		logic [7:0] wrap;
		logic [7:0] pattern;
		logic [7:0] integ;
	} fcrb_cfg_s;
	typedef struct packed {
		logic       valid;
		logic       write;
		logic       nonvol;
		logic [7:0] addr;
		logic [7:0] data;
	} fcrb_cmd_s;
endpackage

// file: rtl/fcrb_top.sv
// flash configuration register bank top
`timescale 1ns/10ps
`default_nettype none
`include "fcrb_regs.svh"
module fcrb_top (
	input  wire logic              CLK_SYS,
	input  wire logic              NRST,
	input  wire logic              LINK_CLK,
	input  wire logic              LINK_NRST,
	input  wire logic              OCTAL_BOOT,
	input  wire fcrb_pkg::fcrb_cmd_s LINK_CMD,
	output logic [7:0]             LINK_RDATA,
	output logic                   LINK_RVALID,
	input  wire logic              CLR_FLAG,
	output logic                   FLAG_PROT,
	output logic                   WEL,
	input  wire logic              WEL_SET,
	output fcrb_pkg::fcrb_cfg_s    ACTIVE_CFG,
	output logic [4:0]             DUMMY_CYCLES,
	output logic                   PAR_CHECK_EN,
	output logic                   CORR_EN,
	output logic                   ERR_PIN_EN,
	output logic                   ERR_EVT_2BIT,
	output logic                   LINE3_INVERT
);
	import fcrb_pkg::*;

	// ==========================================
	// link side: capture command, toggle event
	fcrb_cmd_s  cmd_reg;
	logic       cmd_tgl_reg;
	logic [7:0] rdata_reg;
	logic       rvalid_reg;
	fcrb_cfg_s  nv_reg;
	fcrb_cfg_s  vol_reg;

	always_ff @(posedge LINK_CLK or negedge LINK_NRST) begin
		if (!LINK_NRST) begin
			cmd_reg     <= '0;
			cmd_tgl_reg <= 1'b0;
		end else if (LINK_CMD.valid) begin
			cmd_reg     <= LINK_CMD;
			cmd_tgl_reg <= ~cmd_tgl_reg;
		end
	end

	// ==========================================
	// system side synchronisers
	logic [2:0] tgl_sync_reg;
	logic [1:0] boot_sync_reg;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			tgl_sync_reg  <= 3'h0;
			boot_sync_reg <= 2'h0;
		end else begin
			tgl_sync_reg  <= {tgl_sync_reg[1:0], cmd_tgl_reg};
			boot_sync_reg <= {boot_sync_reg[0], OCTAL_BOOT};
		end
	end
	// sys reset alone can leave the link toggle high; the refill edge is no command
	logic [1:0] arm_reg;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			arm_reg <= 2'h0;
		else if (arm_reg != `FCRB_SYNC_ARM)
			arm_reg <= arm_reg + 2'h1;
	end
	// cmd_reg is stable for a full sync delay after toggle
	wire cmd_evt = (tgl_sync_reg[2] ^ tgl_sync_reg[1]) && (arm_reg == `FCRB_SYNC_ARM);

	// ==========================================
	// decode helpers
	function automatic logic [7:0] rd_byte(input fcrb_cfg_s c, input logic [7:0] a);
		case (a)
			`FCRB_A_IO:    rd_byte = c.io_mode;
			`FCRB_A_DUMMY: rd_byte = c.dummy;
			`FCRB_A_DRIVE: rd_byte = c.drive;
			`FCRB_A_ADDR:  rd_byte = c.addr_len;
			`FCRB_A_XIP:   rd_byte = c.xip;
			`FCRB_A_WRAP:  rd_byte = c.wrap;
			`FCRB_A_PAT:   rd_byte = c.pattern;
			`FCRB_A_INTEG: rd_byte = c.integ;
			// RQ5: reserved reads FFh
			default:       rd_byte = `FCRB_ERASED;
		endcase
	endfunction

	function automatic logic legal(input logic [7:0] a, input logic [7:0] d, input logic ob);
		case (a)
			// RQ18: protocol codes; RQ19: octal boot keeps octal strobe
			`FCRB_A_IO:    legal = ob ? (d == 8'hFF || d == 8'hE7) :
			                     (d == 8'hFF || d == 8'hDF || d == 8'hE7 || d == 8'hC7);
			// RQ17: dummy range
			`FCRB_A_DUMMY: legal = (d <= `FCRB_DUMMY_DEF);
			// RQ16: drive strength codes
			`FCRB_A_DRIVE: legal = (d >= 8'hFC);
			// RQ15: address length codes
			`FCRB_A_ADDR:  legal = (d >= 8'hFE);
			// RQ14: execute-in-place codes
			`FCRB_A_XIP:   legal = (d >= 8'hFD) || (d == 8'hF8);
			// RQ13: wrap codes
			`FCRB_A_WRAP:  legal = (d >= 8'hFC);
			`FCRB_A_PAT:   legal = 1'b1;
			`FCRB_A_INTEG: legal = 1'b1;
			default:       legal = 1'b0;
		endcase
	endfunction

	function automatic fcrb_cfg_s wr_byte(input fcrb_cfg_s c, input logic [7:0] a, input logic [7:0] d);
		fcrb_cfg_s r;
		r = c;
		case (a)
			`FCRB_A_IO:    r.io_mode  = d;
			`FCRB_A_DUMMY: r.dummy    = d;
			`FCRB_A_DRIVE: r.drive    = d;
			`FCRB_A_ADDR:  r.addr_len = d;
			`FCRB_A_XIP:   r.xip      = d;
			`FCRB_A_WRAP:  r.wrap     = d;
			`FCRB_A_PAT:   r.pattern  = d;
			// reserved bits of 0Bh stay erased
			`FCRB_A_INTEG: r.integ    = d | ~`FCRB_INTEG_MSK;
			default:       r = c;
		endcase
		wr_byte = r;
	endfunction

	// RQ3: erased defaults except pattern and dummy
	localparam fcrb_cfg_s CFG_DEF = '{io_mode: `FCRB_ERASED, dummy: `FCRB_DUMMY_DEF,
		drive: `FCRB_ERASED, addr_len: `FCRB_ERASED, xip: `FCRB_ERASED,
		wrap: `FCRB_ERASED, pattern: `FCRB_PAT_RST, integ: `FCRB_ERASED};

	// ==========================================
	// register writes and reads
	// RQ4: only low address byte used
	wire [7:0] c_addr  = cmd_reg.addr;
	wire       c_ok    = legal(c_addr, cmd_reg.data, boot_sync_reg[1]);
	wire       do_wr   = cmd_evt && cmd_reg.write && WEL;
	wire       wr_good = do_wr && c_ok;
	wire       wr_bad  = do_wr && !c_ok;

	// nonvolatile store keeps contents across reset (power-on only loads defaults)
	// power-on value only, NRST must not wipe the store
	logic nv_init_reg = 1'b0;
	always_ff @(posedge CLK_SYS) begin
		if (!nv_init_reg)
			nv_reg <= CFG_DEF;
		else if (wr_good && cmd_reg.nonvol)
			nv_reg <= wr_byte(nv_reg, c_addr, cmd_reg.data);
	end
	always_ff @(posedge CLK_SYS) begin
		nv_init_reg <= 1'b1;
	end

	// RQ1: reload volatile from nonvolatile after reset
	logic load_reg;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			load_reg <= 1'b1;
		else
			load_reg <= 1'b0;
	end

	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			vol_reg <= CFG_DEF;
		else if (load_reg)
			vol_reg <= nv_reg;
		else if (wr_good && !cmd_reg.nonvol)
			vol_reg <= wr_byte(vol_reg, c_addr, cmd_reg.data);
	end

	// RQ2: volatile write lands in active config; RQ22: nonvolatile write does not
	fcrb_cfg_s act_reg;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			act_reg <= CFG_DEF;
		else if (load_reg)
			act_reg <= nv_reg;
		else if (wr_good && !cmd_reg.nonvol)
			act_reg <= wr_byte(vol_reg, c_addr, cmd_reg.data);
	end

	// RQ6: bad setting sets protection flag, set wins
	// RQ21: protection flag is flag status bit 1
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			FLAG_PROT <= 1'b0;
		else if (wr_bad)
			FLAG_PROT <= 1'b1;
		else if (CLR_FLAG)
			FLAG_PROT <= 1'b0;
	end

	// RQ6: write latch cleared after any write
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST)
			WEL <= 1'b0;
		else if (do_wr)
			WEL <= 1'b0;
		else if (WEL_SET)
			WEL <= 1'b1;
	end

	// read data back toward link via toggle
	logic [7:0] rd_sys_reg;
	logic       rd_tgl_reg;
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			rd_sys_reg <= `FCRB_ERASED;
			rd_tgl_reg <= 1'b0;
		end else if (cmd_evt && !cmd_reg.write) begin
			rd_sys_reg <= rd_byte(cmd_reg.nonvol ? nv_reg : vol_reg, c_addr);
			rd_tgl_reg <= ~rd_tgl_reg;
		end
	end

	logic [2:0] rd_sync_reg;
	always_ff @(posedge LINK_CLK or negedge LINK_NRST) begin
		if (!LINK_NRST) begin
			rd_sync_reg <= 3'h0;
			rdata_reg   <= 8'h00;
			rvalid_reg  <= 1'b0;
		end else begin
			rd_sync_reg <= {rd_sync_reg[1:0], rd_tgl_reg};
			rvalid_reg  <= rd_sync_reg[2] ^ rd_sync_reg[1];
			if (rd_sync_reg[2] ^ rd_sync_reg[1])
				rdata_reg <= rd_sys_reg;
		end
	end
	assign LINK_RDATA  = rdata_reg;
	assign LINK_RVALID = rvalid_reg;

	// ==========================================
	// decoded active settings
	assign ACTIVE_CFG = act_reg;
	// RQ17: 00h acts as 1Fh; RQ20: host sizes it
	assign DUMMY_CYCLES = (act_reg.dummy == 8'h00) ? act_reg.dummy[4:0] | 5'h1F : act_reg.dummy[4:0];
	// RQ8: parity enable active low
	assign PAR_CHECK_EN = !act_reg.integ[`FCRB_B_PAR];
	// RQ11: correction enable active low
	assign CORR_EN      = !act_reg.integ[`FCRB_B_ECC];
	// RQ10: error pin enable active low
	assign ERR_PIN_EN   = !act_reg.integ[`FCRB_B_PIN];
	// RQ9: event select valid only with correction
	assign ERR_EVT_2BIT = act_reg.integ[`FCRB_B_EVT] && CORR_EN;
	// RQ7: data line three invert
	// RQ12: pattern held in act_reg.pattern
	assign LINE3_INVERT = !act_reg.integ[`FCRB_B_SSO];
endmodule // fcrb_top
`default_nettype wire

// file: tb/fcrb_checker.sv
// property checker for the config register bank
`timescale 1ns/10ps
`default_nettype none
module fcrb_checker (
	input wire logic                CLK_SYS,
	input wire logic                NRST,
	input wire logic                CLR_FLAG,
	input wire logic                FLAG_PROT,
	input wire logic                WEL,
	input wire fcrb_pkg::fcrb_cfg_s ACTIVE_CFG,
	input wire logic [4:0]          DUMMY_CYCLES,
	input wire logic                PAR_CHECK_EN,
	input wire logic                CORR_EN,
	input wire logic                ERR_PIN_EN,
	input wire logic                ERR_EVT_2BIT,
	input wire logic                LINE3_INVERT
);
	import fcrb_pkg::*;
	// ==========
	// decode and error properties
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);
	a_dummy_zero: assert property (ACTIVE_CFG.dummy == 8'h00 |-> DUMMY_CYCLES == 5'h1F)
		else $error("dummy zero decode wrong");
	a_dummy_pass: assert property (ACTIVE_CFG.dummy inside {[8'h01:8'h1E]} |-> DUMMY_CYCLES == ACTIVE_CFG.dummy[4:0])
		else $error("dummy count decode wrong");
	a_line3_inv: assert property (LINE3_INVERT == !ACTIVE_CFG.integ[6])
		else $error("line three invert wrong");
	a_parity_en: assert property (PAR_CHECK_EN == !ACTIVE_CFG.integ[3])
		else $error("parity enable wrong");
	a_err_event: assert property (CORR_EN |-> ERR_EVT_2BIT == ACTIVE_CFG.integ[2])
		else $error("error event select wrong");
	a_err_pin: assert property (ERR_PIN_EN == !ACTIVE_CFG.integ[1])
		else $error("error pin enable wrong");
	a_corr_en: assert property (CORR_EN == !ACTIVE_CFG.integ[0])
		else $error("correction enable wrong");
	a_flag_sticky: assert property (FLAG_PROT && !CLR_FLAG |=> FLAG_PROT)
		else $error("protection flag dropped");
	a_flag_wel: assert property ($rose(FLAG_PROT) |-> ##[0:2] !WEL)
		else $error("latch not cleared on error");
	a_io_legal: assert property (ACTIVE_CFG.io_mode inside {8'hFF, 8'hDF, 8'hE7, 8'hC7})
		else $error("illegal io mode active");
endmodule // fcrb_checker
bind fcrb_top fcrb_checker u_chk (.CLK_SYS, .NRST, .CLR_FLAG, .FLAG_PROT, .WEL, .ACTIVE_CFG, .DUMMY_CYCLES,
	.PAR_CHECK_EN, .CORR_EN, .ERR_PIN_EN, .ERR_EVT_2BIT, .LINE3_INVERT);
`default_nettype wire

// file: tb/fcrb_host_model.sv
// host controller model issuing register commands
`timescale 1ns/10ps
`default_nettype none
module fcrb_host_model (
	input  wire logic           link_clk,
	output fcrb_pkg::fcrb_cmd_s cmd,
	input  wire logic [7:0]     rdata,
	input  wire logic           rvalid
);
	import fcrb_pkg::*;
	initial cmd = '0;
	// ==========
	// one command, read answer awaited
	task automatic issue(input logic w, nv, input logic [7:0] a, d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge link_clk) #1;
		cmd = {1'b1, w, nv, a, d};
		@(posedge link_clk) #1;
		// released fields invert so a stale copy never passes
		cmd = {1'b0, ~w, ~nv, ~a, ~d};
		while (!w && rvalid !== 1'b1 && n < 40) begin
			@(posedge link_clk) #1;
			n++;
		end
		// a missing answer reads as unknown so the compare fails
		q = (w || rvalid === 1'b1) ? rdata : 'x;
		// spacing keeps commands at least twelve link cycles apart
		repeat (12) @(posedge link_clk);
	endtask
endmodule // fcrb_host_model
`default_nettype wire

// file: tb/fcrb_top_tb.sv
// testbench for the config register bank
`timescale 1ns/10ps
`default_nettype none
module fcrb_top_tb;
	import fcrb_pkg::*;
	logic clk_sys = 0, link_clk = 0, nrst = 0, link_nrst = 0, octal_boot = 0, clr_flag = 0, wel_set = 0;
	logic [7:0] rdata, q, e;
	logic rvalid, flag, wel;
	logic [4:0] dum;
	fcrb_cmd_s cmd;
	fcrb_cfg_s cfg;
	int fail_count = 0, compares = 0, cyc = 0;
	logic [23:0] tbl [19] = '{24'h00FF07, 24'h00DF07, 24'h00E707, 24'h00C707, 24'h011E06, 24'h010006,
		24'h03FC05, 24'h03FD05, 24'h03FE05, 24'h05FE04, 24'h06FE03, 24'h06FD03, 24'h06F803,
		24'h07FE02, 24'h07FD02, 24'h07FC02, 24'h0AA501, 24'h0B4400, 24'h0B0000};
	always #5 clk_sys = ~clk_sys;
	// link clock runs free, its crossings need it
	always #6 link_clk = ~link_clk;
	fcrb_top dut (.CLK_SYS(clk_sys), .NRST(nrst), .LINK_CLK(link_clk), .LINK_NRST(link_nrst),
		.OCTAL_BOOT(octal_boot), .LINK_CMD(cmd), .LINK_RDATA(rdata), .LINK_RVALID(rvalid), .CLR_FLAG(clr_flag),
		.FLAG_PROT(flag), .WEL(wel), .WEL_SET(wel_set), .ACTIVE_CFG(cfg), .DUMMY_CYCLES(dum),
		.PAR_CHECK_EN(), .CORR_EN(), .ERR_PIN_EN(), .ERR_EVT_2BIT(), .LINE3_INVERT());
	fcrb_host_model u_host (.link_clk(link_clk), .cmd(cmd), .rdata(rdata), .rvalid(rvalid));
	// ==========
	// shared tasks
	task automatic chk(input string n, input logic [63:0] got, exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic pulse_sys(ref logic s);
		@(posedge clk_sys) #1 s = 1;
		@(posedge clk_sys) #1 s = 0;
	endtask
	task automatic wrv(input logic nv, input logic [7:0] a, d);
		pulse_sys(wel_set);
		u_host.issue(1, nv, a, d, q);
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	// ==========
	// test sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		#1 nrst = 1;
		link_nrst = 1;
		repeat (3) @(posedge clk_sys);
		chk("reset cfg", cfg, 64'hFF1FFFFFFFFF55FF);
		u_host.issue(0, 1, 8'h0B, 8'h00, q); chk("nv integ", q, 8'hFF);
		$display("defaults done");
		foreach (tbl[i]) begin
			wrv(0, tbl[i][23:16], tbl[i][15:8]);
			e = (tbl[i][23:16] == 8'h0B) ? (tbl[i][15:8] | 8'hB0) : tbl[i][15:8];
			chk("active byte", cfg[8*tbl[i][7:0] +: 8], e);
			u_host.issue(0, 0, tbl[i][23:16], 8'h00, q); chk("vol read", q, e);
		end
		chk("dummy zero", dum, 5'h1F);
		$display("codes done");
		u_host.issue(0, 0, 8'h04, 8'h00, q); chk("rsv read", q, 8'hFF);
		u_host.issue(0, 1, 8'h40, 8'h00, q); chk("rsv nv read", q, 8'hFF);
		wrv(0, 8'h05, 8'h12); chk("rsv set", {cfg.addr_len, flag, wel}, {8'hFE, 2'b10});
		pulse_sys(clr_flag);
		wrv(0, 8'h02, 8'h00); chk("rsv addr", {flag, wel}, 2'b10);
		pulse_sys(clr_flag);
		u_host.issue(1, 0, 8'h0A, 8'h11, q); chk("no latch", {cfg.pattern, flag}, {8'hA5, 1'b0});
		$display("reserved done");
		wrv(1, 8'h0A, 8'h3C); chk("nv no effect", cfg.pattern, 8'hA5);
		@(posedge clk_sys) #1 nrst = 0;
		repeat (2) @(posedge clk_sys);
		#1 nrst = 1;
		repeat (3) @(posedge clk_sys);
		chk("nv reload", {cfg.io_mode, cfg.pattern}, 16'hFF3C);
		$display("reload done");
		#1 octal_boot = 1;
		repeat (3) @(posedge clk_sys);
		wrv(0, 8'h00, 8'hDF); chk("octal spi", {cfg.io_mode, flag}, {8'hFF, 1'b1});
		pulse_sys(clr_flag);
		wrv(0, 8'h00, 8'hE7); chk("octal ddr", {cfg.io_mode, flag}, {8'hE7, 1'b0});
		$display("octal done");
		conclude();
	end
endmodule // fcrb_top_tb
`default_nettype wire
